/* File: inc/mpg_regs.svh */
// Purpose: named constants of the multiplexed multipulse generator
// Assumes: included by bare name from design files
// Notes:   definitions only
`ifndef MPG_REGS_SVH
`define MPG_REGS_SVH

`define MPG_CHANNELS      4
`define MPG_CH_W          2
`define MPG_ANGLE_W       16
`define MPG_TICK_W        24
`define MPG_PROD_W        40
`define MPG_KEY_W         16
// unlock key value is arbitrary
`define MPG_KEY_VALUE     16'hA5C3
// 45 of 720 crank degrees is one sixteenth of the cycle
`define MPG_SPACING_SHIFT 4
`define MPG_CH_FIRST      2'h0
`define MPG_CH_STEP       2'h1
`define MPG_TICK_ZERO     24'h000000
`define MPG_TICK_ONE      24'h000001
`define MPG_FIRE_NONE     3'h0
`define MPG_FIRE_PILOT    0
`define MPG_FIRE_PRE      1
`define MPG_FIRE_MAIN     2

`endif

/* File: inc/mpg_pkg.sv */
// Purpose: types shared by both ends of the multipulse generator link
// Assumes: mpg_regs.svh gives the widths
// Notes:   no imports anywhere; use mpg_pkg::name
`include "mpg_regs.svh"

package mpg_pkg;

   // settings of one channel
   typedef struct packed {
      logic                       pulse_group_enable;
      logic                       first_early_pulse_enable;
      logic                       second_early_pulse_enable;
      logic                       first_late_pulse_enable;
      logic                       second_late_pulse_enable;
      logic [`MPG_ANGLE_W-1:0]    main_pulse_angle;
      logic [`MPG_TICK_W-1:0]     main_pulse_length;
      logic [`MPG_TICK_W-1:0]     first_early_lead_ticks;
      logic [`MPG_TICK_W-1:0]     first_early_length;
      logic [`MPG_TICK_W-1:0]     second_early_lead_ticks;
      logic [`MPG_TICK_W-1:0]     second_early_length;
      logic [`MPG_TICK_W-1:0]     first_late_gap_ticks;
      logic [`MPG_TICK_W-1:0]     first_late_length;
      logic [`MPG_TICK_W-1:0]     second_late_gap_ticks;
      logic [`MPG_TICK_W-1:0]     second_late_length;
      logic [`MPG_ANGLE_W-1:0]    channel_switch_angle;
   } mpg_chan_settings_t;

   // engine position bundle from the tracker
   typedef struct packed {
      logic                       sync_valid;
      logic [`MPG_ANGLE_W-1:0]    crank_angle_tick;
      logic [`MPG_ANGLE_W-1:0]    cycle_ticks;
      logic [`MPG_TICK_W-1:0]     tick_period;
   } mpg_engine_position_bundle_t;

   // one-hot states of a pulse timer
   typedef enum logic [2:0] {
      MPG_TMR_IDLE = 3'h1,
      MPG_TMR_WAIT = 3'h2,
      MPG_TMR_HIGH = 3'h4
   } mpg_tmr_state_t;

endpackage : mpg_pkg

/* File: inc/mpg_if.sv */
// Purpose: link between the pulse generator and its surrounding logic
// Assumes: both ends run on the same core clock
// Notes:   no clocking block
`timescale 1ns/1ps
`default_nettype none
`include "mpg_regs.svh"

interface mpg_if;
   mpg_pkg::mpg_engine_position_bundle_t  engine_position_bundle;
   logic [`MPG_KEY_W-1:0]                 unlock_key;
   mpg_pkg::mpg_chan_settings_t           channel_pulse_settings [`MPG_CHANNELS];
   logic [`MPG_CHANNELS-1:0]              channel_pulse_out;
   logic                                  switch_strobe;

   modport dev (
      input  engine_position_bundle,
      input  unlock_key,
      input  channel_pulse_settings,
      output channel_pulse_out,
      output switch_strobe
   );

   modport host (
      output engine_position_bundle,
      output unlock_key,
      output channel_pulse_settings,
      input  channel_pulse_out,
      input  switch_strobe
   );
endinterface : mpg_if

`default_nettype wire

/* File: logic/mpg_pulse_timer.sv */
// Purpose: one pulse, delayed then held for a length, in clock ticks
// Assumes: start is a one-cycle pulse
// Notes:   clear aborts the pulse at once
`timescale 1ns/1ps
`default_nettype none
`include "mpg_regs.svh"

module mpg_pulse_timer (
   input  wire logic                    core_clk,
   input  wire logic                    sys_rst,
   input  wire logic                    clear,
   input  wire logic                    start,
   input  wire logic [`MPG_TICK_W-1:0]  delay_ticks,
   input  wire logic [`MPG_TICK_W-1:0]  length_ticks,
   output logic                         active,
   output logic                         done
);

   mpg_pkg::mpg_tmr_state_t  state_ff;
   logic [`MPG_TICK_W-1:0]   cnt_ff;
   logic [`MPG_TICK_W-1:0]   len_ff;
   logic                     done_ff;

   //---------------------------------------------------------------
   // sequencing
   //---------------------------------------------------------------
   // delay phase, then high phase; done when high phase ends
   always_ff @(posedge core_clk)
   begin
      done_ff <= 1'b0;
      if (sys_rst || clear)
      begin
         state_ff <= mpg_pkg::MPG_TMR_IDLE;
         cnt_ff   <= `MPG_TICK_ZERO;
         len_ff   <= `MPG_TICK_ZERO;
      end
      else
      begin
         case (state_ff)
            mpg_pkg::MPG_TMR_IDLE:
            begin
               if (start)
               begin
                  len_ff <= length_ticks;
                  if (delay_ticks != `MPG_TICK_ZERO)
                  begin
                     state_ff <= mpg_pkg::MPG_TMR_WAIT;
                     cnt_ff   <= delay_ticks;
                  end
                  else if (length_ticks != `MPG_TICK_ZERO)
                  begin
                     state_ff <= mpg_pkg::MPG_TMR_HIGH;
                     cnt_ff   <= length_ticks;
                  end
                  else
                     done_ff <= 1'b1;   // zero length: no pulse
               end
            end
            mpg_pkg::MPG_TMR_WAIT:
            begin
               if (cnt_ff == `MPG_TICK_ONE)
               begin
                  if (len_ff != `MPG_TICK_ZERO)
                  begin
                     state_ff <= mpg_pkg::MPG_TMR_HIGH;
                     cnt_ff   <= len_ff;
                  end
                  else
                  begin
                     state_ff <= mpg_pkg::MPG_TMR_IDLE;
                  end
               end
               else
                  cnt_ff <= cnt_ff - `MPG_TICK_ONE;
            end
            mpg_pkg::MPG_TMR_HIGH:
            begin
               if (cnt_ff == `MPG_TICK_ONE)
               begin
                  state_ff <= mpg_pkg::MPG_TMR_IDLE;
               end
               else
                  cnt_ff <= cnt_ff - `MPG_TICK_ONE;
            end
            default:
               state_ff <= mpg_pkg::MPG_TMR_IDLE;
         endcase
      end
   end

   assign active = (state_ff == mpg_pkg::MPG_TMR_HIGH);
   // done in the last cycle of the final phase, so a chained gap is not one tick long
   assign done   = done_ff ||
                   ((state_ff == mpg_pkg::MPG_TMR_HIGH) && (cnt_ff == `MPG_TICK_ONE)) ||
                   ((state_ff == mpg_pkg::MPG_TMR_WAIT) && (cnt_ff == `MPG_TICK_ONE) &&
                    (len_ff == `MPG_TICK_ZERO));

endmodule : mpg_pulse_timer

`default_nettype wire

/* File: logic/mpg_device.sv */
// Purpose: four-channel multiplexed five-pulse generator, crank synchronous
// Assumes: bundle straight from the tracker, key fed back one stage late
// Notes:   one timing engine serves the active channel only
//
// Behaviour
// - group enable gates all five pulses
// - pilot pulse only when pilot enabled
// - pre pulse only when pre enabled
// - after pulse only when after enabled
// - post pulse needs post and after enables
// - main starts at main angle, lasts length
// - pilot leads main start by clock ticks
// - pre leads main start by clock ticks
// - after follows main end by gap ticks
// - post follows after end by gap ticks
// - each pulse held for its own length
// - all tick values are 24 bits wide
// - host flags switch angle less than 45 degrees past main
// - shared engine advances channel at switch angle
// - host passes settings unaltered, switch angle order unchecked
// - switch strobe lasts exactly one clock
// - four separate channel pulse outputs
// - outputs stay low without valid key
// - host returns key through one register
// - host passes position bundle unaltered
// - whole block evaluated every 40 MHz clock
// - angles are crank ticks over full cycle
`timescale 1ns/1ps
`default_nettype none
`include "mpg_regs.svh"

module mpg_device (
   input  wire logic  core_clk,
   input  wire logic  sys_rst,
   mpg_if.dev         link
);

   //---------------------------------------------------------------
   // helpers
   //---------------------------------------------------------------
   // forward distance in crank ticks, wrapping at the cycle length
   function automatic logic [`MPG_ANGLE_W-1:0] mpg_ang_dist(
      input logic [`MPG_ANGLE_W-1:0] from_a,
      input logic [`MPG_ANGLE_W-1:0] to_a,
      input logic [`MPG_ANGLE_W-1:0] cycle
   );
      logic [`MPG_ANGLE_W:0] sum;
      sum = {1'b0, to_a} + {1'b0, cycle} - {1'b0, from_a};
      if (to_a >= from_a)
         mpg_ang_dist = to_a - from_a;
      else
         mpg_ang_dist = sum[`MPG_ANGLE_W-1:0];
   endfunction : mpg_ang_dist

   //---------------------------------------------------------------
   // state
   //---------------------------------------------------------------
   logic [`MPG_CH_W-1:0]       ch_ff;
   logic [2:0]                 fired_ff;
   logic [`MPG_CHANNELS-1:0]   out_ff;
   logic                       strobe_ff;

   mpg_pkg::mpg_chan_settings_t           cur;
   mpg_pkg::mpg_engine_position_bundle_t  pos;
   logic                        key_ok;
   logic                        grp_on;
   logic [`MPG_ANGLE_W-1:0]     cats_to_main;
   logic [`MPG_PROD_W-1:0]      ticks_to_main;
   logic                        cut;
   logic                        pilot_go;
   logic                        pre_go;
   logic                        main_go;
   logic                        after_go;
   logic                        post_go;
   logic [4:0]                  act;
   logic [4:0]                  done;

   //---------------------------------------------------------------
   // active channel decode
   //---------------------------------------------------------------
   // settings of the channel now owning the engine
   assign cur    = link.channel_pulse_settings[ch_ff];
   assign pos    = link.engine_position_bundle;
   assign key_ok = (link.unlock_key == `MPG_KEY_VALUE);
   assign grp_on = pos.sync_valid && cur.pulse_group_enable;

   // time until main start, predicted from the tick period
   assign cats_to_main  = mpg_ang_dist(pos.crank_angle_tick, cur.main_pulse_angle,
                                       pos.cycle_ticks);
   assign ticks_to_main = cats_to_main * pos.tick_period;

   // channel switch point
   assign cut = pos.sync_valid &&
                (pos.crank_angle_tick == cur.channel_switch_angle);

   //---------------------------------------------------------------
   // pulse start conditions
   //---------------------------------------------------------------
   // early pulses fire once when the lead time is reached
   assign pilot_go = grp_on && cur.first_early_pulse_enable && !cut &&
                     !fired_ff[`MPG_FIRE_PILOT] &&
                     (ticks_to_main <= {16'h0000, cur.first_early_lead_ticks});
   assign pre_go   = grp_on && cur.second_early_pulse_enable && !cut &&
                     !fired_ff[`MPG_FIRE_PRE] &&
                     (ticks_to_main <= {16'h0000, cur.second_early_lead_ticks});
   // main fires once when the crank reaches its angle
   assign main_go  = grp_on && !cut && !fired_ff[`MPG_FIRE_MAIN] &&
                     (pos.crank_angle_tick == cur.main_pulse_angle);
   // late pulses chain off the end of the previous pulse
   assign after_go = grp_on && cur.first_late_pulse_enable && done[2];
   assign post_go  = grp_on && cur.first_late_pulse_enable &&
                     cur.second_late_pulse_enable && done[3];

   //---------------------------------------------------------------
   // pulse timers
   //---------------------------------------------------------------
   // pilot, no delay
   mpg_pulse_timer u_pilot (
      .core_clk     (core_clk),
      .sys_rst      (sys_rst),
      .clear        (cut),
      .start        (pilot_go),
      .delay_ticks  (`MPG_TICK_ZERO),
      .length_ticks (cur.first_early_length),
      .active       (act[0]),
      .done         (done[0])
   );

   // pre, no delay
   mpg_pulse_timer u_pre (
      .core_clk     (core_clk),
      .sys_rst      (sys_rst),
      .clear        (cut),
      .start        (pre_go),
      .delay_ticks  (`MPG_TICK_ZERO),
      .length_ticks (cur.second_early_length),
      .active       (act[1]),
      .done         (done[1])
   );

   // main, held for its length
   mpg_pulse_timer u_main (
      .core_clk     (core_clk),
      .sys_rst      (sys_rst),
      .clear        (cut),
      .start        (main_go),
      .delay_ticks  (`MPG_TICK_ZERO),
      .length_ticks (cur.main_pulse_length),
      .active       (act[2]),
      .done         (done[2])
   );

   // after, gap then length
   mpg_pulse_timer u_after (
      .core_clk     (core_clk),
      .sys_rst      (sys_rst),
      .clear        (cut),
      .start        (after_go),
      .delay_ticks  (cur.first_late_gap_ticks),
      .length_ticks (cur.first_late_length),
      .active       (act[3]),
      .done         (done[3])
   );

   // post, gap then length
   mpg_pulse_timer u_post (
      .core_clk     (core_clk),
      .sys_rst      (sys_rst),
      .clear        (cut),
      .start        (post_go),
      .delay_ticks  (cur.second_late_gap_ticks),
      .length_ticks (cur.second_late_length),
      .active       (act[4]),
      .done         (done[4])
   );

   //---------------------------------------------------------------
   // sequencing state
   //---------------------------------------------------------------
   // once-per-cycle fire marks, cleared at the switch angle
   always_ff @(posedge core_clk)
   begin
      if (sys_rst || cut)
         fired_ff <= `MPG_FIRE_NONE;
      else
      begin
         if (pilot_go)
            fired_ff[`MPG_FIRE_PILOT] <= 1'b1;
         if (pre_go)
            fired_ff[`MPG_FIRE_PRE] <= 1'b1;
         if (main_go)
            fired_ff[`MPG_FIRE_MAIN] <= 1'b1;
      end
   end

   // move engine to the next channel
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         ch_ff <= `MPG_CH_FIRST;
      else if (cut)
         ch_ff <= ch_ff + `MPG_CH_STEP;
   end

   //---------------------------------------------------------------
   // outputs
   //---------------------------------------------------------------
   // one-clock strobe at each switch angle
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         strobe_ff <= 1'b0;
      else
         strobe_ff <= cut;
   end

   // active channel carries the OR of its pulses, key gated
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         out_ff <= '0;
      else
      begin
         for (int i = 0; i < `MPG_CHANNELS; i++)
            out_ff[i] <= key_ok && !cut && grp_on && (ch_ff == i[`MPG_CH_W-1:0]) &&
                         (|act);
      end
   end

   assign link.channel_pulse_out = out_ff;
   assign link.switch_strobe     = strobe_ff;

endmodule : mpg_device

`default_nettype wire

/* File: logic/mpg_host.sv */
// Purpose: surrounding logic: tracker bundle, key feedback, settings
// Assumes: key and bundle come from the supervisor and tracker
// Notes:   also flags settings that break the angle spacing
`timescale 1ns/1ps
`default_nettype none
`include "mpg_regs.svh"

module mpg_host (
   input  wire logic                                  core_clk,
   input  wire logic                                  sys_rst,
   input  wire mpg_pkg::mpg_engine_position_bundle_t  tracker_bundle,
   input  wire logic [`MPG_KEY_W-1:0]                 supervisor_key,
   input  wire mpg_pkg::mpg_chan_settings_t           user_settings [`MPG_CHANNELS],
   output logic [`MPG_CHANNELS-1:0]                   channel_pulses,
   output logic                                       switch_seen,
   output logic                                       spacing_ok,
   mpg_if.host                                        link
);

   logic [`MPG_KEY_W-1:0]      key_ff;
   logic [`MPG_CHANNELS-1:0]   pulses_ff;
   logic                       seen_ff;
   logic                       spacing_ff;
   logic [`MPG_CHANNELS-1:0]   nxt_spacing;

   // forward distance in crank ticks with cycle wrap
   function automatic logic [`MPG_ANGLE_W-1:0] mpg_host_dist(
      input logic [`MPG_ANGLE_W-1:0] from_a,
      input logic [`MPG_ANGLE_W-1:0] to_a,
      input logic [`MPG_ANGLE_W-1:0] cycle
   );
      logic [`MPG_ANGLE_W:0] sum;
      sum = {1'b0, to_a} + {1'b0, cycle} - {1'b0, from_a};
      if (to_a >= from_a)
         mpg_host_dist = to_a - from_a;
      else
         mpg_host_dist = sum[`MPG_ANGLE_W-1:0];
   endfunction : mpg_host_dist

   //---------------------------------------------------------------
   // link drive
   //---------------------------------------------------------------
   // key returned through exactly one register stage
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         key_ff <= '0;
      else
         key_ff <= supervisor_key;
   end

   assign link.engine_position_bundle = tracker_bundle;
   assign link.unlock_key             = key_ff;
   assign link.channel_pulse_settings = user_settings;

   //---------------------------------------------------------------
   // spacing check and output capture
   //---------------------------------------------------------------
   // switch angle must be at least 45 crank degrees past main start
   always_comb
   begin
      for (int i = 0; i < `MPG_CHANNELS; i++)
         nxt_spacing[i] = mpg_host_dist(user_settings[i].main_pulse_angle,
                                        user_settings[i].channel_switch_angle,
                                        tracker_bundle.cycle_ticks) >=
                          (tracker_bundle.cycle_ticks >> `MPG_SPACING_SHIFT);
   end

   // registered view of the pulse outputs
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         pulses_ff  <= '0;
         seen_ff    <= 1'b0;
         spacing_ff <= 1'b0;
      end
      else
      begin
         pulses_ff  <= link.channel_pulse_out;
         seen_ff    <= link.switch_strobe;
         spacing_ff <= &nxt_spacing;
      end
   end

   assign channel_pulses = pulses_ff;
   assign switch_seen    = seen_ff;
   assign spacing_ok     = spacing_ff;

endmodule : mpg_host

`default_nettype wire

/* File: bench/mpg_link_monitor.sv */
// Purpose: assertions on the link between generator and host
// Assumes: one core clock, synchronous reset active high
// Notes:   sees the interface signals only
`timescale 1ns/1ps
`default_nettype none
`include "mpg_regs.svh"

module mpg_link_monitor (
   input wire logic                                 core_clk,
   input wire logic                                 sys_rst,
   input wire mpg_pkg::mpg_engine_position_bundle_t engine_position_bundle,
   input wire logic [`MPG_KEY_W-1:0]                unlock_key,
   input wire mpg_pkg::mpg_chan_settings_t          channel_pulse_settings [`MPG_CHANNELS],
   input wire logic [`MPG_CHANNELS-1:0]             channel_pulse_out,
   input wire logic                                 switch_strobe
);
   // ------------------------
   // helpers
   // ------------------------
   logic [1:0]                  act_ch_ff;
   mpg_pkg::mpg_chan_settings_t act_set;
   logic                        cut_hit;
   logic                        main_hit;

   // active channel follows the strobes
   always_ff @(posedge core_clk)
      if (sys_rst)
         act_ch_ff <= `MPG_CH_FIRST;
      else if (switch_strobe)
         act_ch_ff <= act_ch_ff + `MPG_CH_STEP;

   // crank reaching the angles of the active channel
   assign act_set  = channel_pulse_settings[act_ch_ff];
   assign cut_hit  = engine_position_bundle.sync_valid
                     && engine_position_bundle.crank_angle_tick == act_set.channel_switch_angle;
   assign main_hit = unlock_key == `MPG_KEY_VALUE && engine_position_bundle.sync_valid
                     && engine_position_bundle.crank_angle_tick == act_set.main_pulse_angle
                     && act_set.pulse_group_enable && act_set.main_pulse_length != `MPG_TICK_ZERO;

   // ------------------------
   // properties
   // ------------------------
   default clocking cb_mon @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_strobe_single;
      switch_strobe |=> !switch_strobe;
   endproperty
   a_strobe_single: assert property (p_strobe_single) else $error("switch strobe too long");

   property p_cut_strobe;
      cut_hit |-> ##1 switch_strobe;
   endproperty
   a_cut_strobe: assert property (p_cut_strobe) else $error("switch strobe missing");

   property p_strobe_cause;
      switch_strobe |-> $past(cut_hit);
   endproperty
   a_strobe_cause: assert property (p_strobe_cause) else $error("switch strobe without cut");

   property p_cut_clears;
      switch_strobe |-> channel_pulse_out == 4'h0;
   endproperty
   a_cut_clears: assert property (p_cut_clears) else $error("pulse alive at cut");

   property p_one_channel;
      (channel_pulse_out & ~(4'h1 << act_ch_ff)) == 4'h0;
   endproperty
   a_one_channel: assert property (p_one_channel) else $error("idle channel pulsing");

   property p_key_lock;
      (unlock_key != `MPG_KEY_VALUE) [*3] |-> channel_pulse_out == 4'h0;
   endproperty
   a_key_lock: assert property (p_key_lock) else $error("output without key");

   property p_group_off;
      (!act_set.pulse_group_enable) [*3] |-> channel_pulse_out == 4'h0;
   endproperty
   a_group_off: assert property (p_group_off) else $error("output with group off");

   property p_main_rise;
      main_hit |-> ##2 channel_pulse_out[act_ch_ff];
   endproperty
   a_main_rise: assert property (p_main_rise) else $error("main pulse late");
endmodule : mpg_link_monitor

`default_nettype wire

/* File: bench/tb_multiplexed_multipulse_generator.sv */
// Purpose: both ends joined, user sides driven, link watched
// Assumes: crank steps one tick per clock, 256 ticks per cycle
// Notes:   outputs compared at falling edges
`timescale 1ns/1ps
`default_nettype none
`include "mpg_regs.svh"

module tb_multiplexed_multipulse_generator;
   logic                                 core_clk = 1'b0;
   logic                                 sys_rst = 1'b1;
   mpg_pkg::mpg_engine_position_bundle_t tracker_bundle;
   logic [`MPG_KEY_W-1:0]                supervisor_key;
   mpg_pkg::mpg_chan_settings_t          user_settings [`MPG_CHANNELS];
   logic [`MPG_CHANNELS-1:0]             channel_pulses;
   logic                                 switch_seen;
   logic                                 spacing_ok;
   logic [1:0][15:0]                     hist;
   logic [3:0]                           prev_out;
   logic                                 prev_strobe;
   int                                   n_fail = 0;
   int                                   total_checks = 0;

   mpg_if link ();
   mpg_host i_mpg_host (.core_clk(core_clk), .sys_rst(sys_rst), .tracker_bundle(tracker_bundle),
      .supervisor_key(supervisor_key), .user_settings(user_settings), .channel_pulses(channel_pulses),
      .switch_seen(switch_seen), .spacing_ok(spacing_ok), .link(link.host));
   mpg_device i_mpg_device (.core_clk(core_clk), .sys_rst(sys_rst), .link(link.dev));
   mpg_link_monitor i_mpg_link_monitor (.core_clk(core_clk), .sys_rst(sys_rst),
      .engine_position_bundle(link.engine_position_bundle), .unlock_key(link.unlock_key),
      .channel_pulse_settings(link.channel_pulse_settings), .channel_pulse_out(link.channel_pulse_out),
      .switch_strobe(link.switch_strobe));

   // ------------------------
   // clock, crank and history
   // ------------------------
   always #12.5 core_clk = ~core_clk;

   // crank sweeps one tick per clock
   always @(posedge core_clk)
      if (sys_rst)
         tracker_bundle.crank_angle_tick <= 16'h0001;
      else
         tracker_bundle.crank_angle_tick <= {8'h00, tracker_bundle.crank_angle_tick[7:0] + 8'h01};

   // past ticks and outputs for the comparisons
   always @(negedge core_clk)
   begin
      hist <= {hist[0], tracker_bundle.crank_angle_tick};
      prev_out <= link.channel_pulse_out;
      prev_strobe <= link.switch_strobe;
   end

   // ------------------------
   // tasks
   // ------------------------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run

   task automatic check(input logic [3:0] exp_v, input logic [3:0] got);
      total_checks++;
      if (got !== exp_v)
      begin
         n_fail++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp_v, got);
      end
   endtask : check

   // main at 0x28 past each window start, cut at the next window start
   function automatic mpg_pkg::mpg_chan_settings_t cfg(input logic [1:0] c, input logic [4:0] en);
      return '{en[4], en[3], en[2], en[1], en[0], {8'h00, c, 6'h28}, 24'h000006,
               24'h000014, 24'h000004, 24'h00000A, 24'h000003,
               24'h000004, 24'h000005, 24'h000003, 24'h000002, {8'h00, 2'(c + 2'h1), 6'h00}};
   endfunction : cfg

   // level wanted d ticks after main start
   function automatic logic want(input logic [4:0] en, input int d);
      return en[4] & ((d >= 0 && d < 6) | (en[3] && d >= -20 && d < -16)
             | (en[2] && d >= -10 && d < -7) | (en[1] && d >= 10 && d < 15)
             | (en[0] && en[1] && d >= 18 && d < 20));
   endfunction : want

   // one engine cycle with given enables and key
   task automatic run_cycle(input logic [19:0] en, input logic [15:0] key);
      int         i;
      int         d;
      logic [7:0] hm;
      logic [3:0] ex;
      i = 0;
      while (tracker_bundle.crank_angle_tick !== 16'h0001)
      begin
         @(negedge core_clk);
         i++;
         if (i > 300)
         begin
            n_fail++;
            complete_run();
         end
      end
      @(posedge core_clk);
      supervisor_key <= key;
      for (int c = 0; c < 4; c++)
         user_settings[c] <= cfg(2'(c), en[c*5 +: 5]);
      repeat (256)
      begin
         @(negedge core_clk);
         hm = hist[1][7:0] - 8'h01;
         d = int'($signed(hist[1][7:0] - {hm[7:6], 6'h28}));
         ex = 4'h0;
         if (key == `MPG_KEY_VALUE)
            ex[hm[7:6]] = want(en[hm[7:6]*5 +: 5], d);
         check(ex, link.channel_pulse_out);
         check({3'h0, hist[0][5:0] == 6'h00}, {3'h0, link.switch_strobe});
         check(prev_out, channel_pulses);
         check({3'h0, prev_strobe}, {3'h0, switch_seen});
      end
   endtask : run_cycle

   // ------------------------
   // sequence
   // ------------------------
   initial
   begin
      tracker_bundle = '{1'b1, 16'h0001, 16'h0100, 24'h000001};
      supervisor_key = 16'h0000;
      for (int c = 0; c < 4; c++)
         user_settings[c] = cfg(2'(c), 5'h00);
      hist = {2{16'h0001}};
      prev_out = 4'h0;
      prev_strobe = 1'b0;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      run_cycle({4{5'h1F}}, `MPG_KEY_VALUE ^ 16'h0001);
      run_cycle({4{5'h1F}}, `MPG_KEY_VALUE);
      run_cycle({5'h1A, 5'h1D, 5'h0F, 5'h17}, `MPG_KEY_VALUE);
      check(4'h1, {3'h0, spacing_ok});
      @(posedge core_clk);
      user_settings[1].main_pulse_angle <= 16'h0078;
      repeat (2) @(negedge core_clk);
      check(4'h0, {3'h0, spacing_ok});
      complete_run();
   end
endmodule : tb_multiplexed_multipulse_generator

`default_nettype wire
